// ---- core/mpanel_consts.svh ----
`ifndef MPANEL_CONSTS_SVH
`define MPANEL_CONSTS_SVH

`define MP_ADDR_W 16
`define MP_RESET_ADDR 16'h0000
`define MP_UCODE_LOADED_ADDR 16'h03fc
`define MP_DAR_RST 16'h0000
`define MP_CMP_RST 16'h0000
`define MP_STAGE_RST 8'h00
`define MP_STAGE_FIRST_IDX 5'h1c
`define MP_STAGE_LAST_IDX 5'h1f
`define MP_CLK_PERIOD_NS 25
`define MP_SYNC_PULSE_NS 40
`define MP_SYNC_PULSE_CYC ((`MP_SYNC_PULSE_NS + `MP_CLK_PERIOD_NS - 1) / `MP_CLK_PERIOD_NS)

`endif

// ---- core/mpanel_pkg.sv ----
package mpanel_pkg;

    typedef enum logic [1:0] {fn_engineer, fn_normal, fn_inline, fn_spare} func_t;

    typedef enum logic [1:0] {pol_normal, pol_run_on_error, pol_single_step, pol_stop_on_error} policy_t;

    typedef enum logic [3:0] {
        loop_between_addrs_mode, run_mode, storage_addr_load_mode, compare_load_mode, data_load_mode,
        storage_write_mode, storage_fetch_mode, microcode_load_mode, spare_mode
    } mode_t;

    typedef enum logic [2:0] {
        routine_error_view, ab_view, dsel_data_addr, dsel_mem_lo, dsel_mem_hi, dsel_instr_addr,
        dsel_compare, dsel_switches
    } dsel_t;

    typedef enum logic [1:0] {ss_off, ss_stop, ss_sync} ss_t;

    typedef struct packed {
        func_t function_sel;
        policy_t policy;
        mode_t mode;
        logic [3:0] reg_sel;
        logic inner_outer;
        dsel_t display_sel;
        logic [15:0] cs_addr_sw;
        logic [7:0] data_sw;
        ss_t stop_sync_one;
        ss_t stop_sync_two;
        logic execute_switch;
        logic uprog_reset_sw;
        logic check_reset_sw;
        logic lamp_test_sw;
    } panel_t;

    typedef struct packed {
        logic iar_load;
        logic [15:0] iar_value;
        logic hard_check;
        logic control_check;
        logic [10:0] err_conds;
        logic [7:0] routine_code;
        logic [7:0] error_code;
        logic [7:0] a_bus;
        logic [7:0] b_bus;
        logic [8:0] reg_rd_data;
        logic [31:0] cs_rd_data;
        logic cs_rd_valid;
        logic prog_ready;
        logic microcode_load_mode_done;
    } ctrl_in_t;

    typedef struct packed {
        logic run_enable;
        logic step_grant;
        logic jump_req;
        logic [15:0] jump_addr;
        logic uprog_reset;
        logic [4:0] reg_idx;
        logic reg_wr;
        logic [7:0] reg_wr_data;
        logic cs_wr;
        logic cs_rd;
        logic [15:0] cs_addr;
        logic [31:0] cs_wr_data;
        logic microcode_load_mode_start;
    } ctrl_out_t;

    typedef struct packed {
        logic [15:0] display_bus;
        logic [8:0] register_display;
        logic [10:0] error_display;
        logic execute_switch_delayed;
        logic microcode_load_mode_lamp;
        logic match_lamp_one;
        logic match_lamp_two;
        logic stop_lamp;
        logic sync_pulse;
    } lamps_t;

endpackage

// ---- core/panel_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module panel_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] raw,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] rise;
    } st_t;

    st_t q;
    st_t d;

    if (W < 1) begin : g_chk
        $error("panel_sync width must be at least one");
    end

    // Two flops before any logic; the rise is taken from the second and third stages.
    always_comb begin
        d = q;
        d.s1 = raw;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.rise = q.s2 & ~q.s3;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.s2;
    assign rise = q.rise;

endmodule

`default_nettype wire

// ---- core/addr_match.sv ----
`timescale 1ns/1ps
`default_nettype none

module addr_match (
    input wire logic enable,
    input wire mpanel_pkg::ss_t setting,
    input wire logic iar_load,
    input wire logic [15:0] iar_value,
    input wire logic [15:0] target,
    output logic hit,
    output logic stop_hit,
    output logic sync_hit
);
    import mpanel_pkg::*;

    // A match is taken as the address enters the instruction register, before it executes.
    always_comb begin
        hit = enable && (setting != ss_off) && iar_load && (iar_value == target);
        stop_hit = hit && (setting == ss_stop);
        sync_hit = hit && (setting == ss_sync);
    end

endmodule

`default_nettype wire

// ---- core/maintenance_panel_control.sv ----
// Notes on behaviour
// - Engineer function honours all switches; normal function honours only error-clear/lamp-test and the display selector.
// - Inline function honours only error-clear/lamp-test, execute, storage address, register selector, inner/outer and display selector switches.
// - Normal error policy halts on hard-check errors only.
// - Run-on-error policy never halts on any error.
// - Single-step policy runs one microblock per execute actuation, then holds.
// - Stop-on-error policy halts on hard-check and control-check errors.
// - Nine modes; all but run, recycle, compare-load need single-step policy.
// - Recycle loops between two addresses; run returns to free running.
// - Execute loads data address, compare or selected register from the switches.
// - Store mode writes the four staging registers to storage at data address.
// - Fetch mode reads the storage word at data address for display.
// - Selector plus inner/outer switch picks one of 32 registers.
// - Display selector routes one of eight sources to the display bus.
// - Sixteen display lamps; routine/error and A/B views split left and right.
// - Microprogram reset forces address 0000 and clears instruction, backup, data address.
// - Error-clear clears error latches and match lamps; lamp test lights all lamps.
// - Nine lamps show the selected register; eleven lamps show error conditions.
// - Execute-delayed lamp lit until the microprogram takes the commanded operation.
// - Switch-address match lights lamp one; stop setting halts, sync setting pulses.
// - Second match unit compares against the compare register instead.
// - Stop lamp lights whenever the machine halts, from error or match.
// - Microcode load lights its lamp, then darkens it and shows 03FC.
// - Match triggers as the address loads, before that microinstruction runs.
// - Sync setting gives one pulse per match, 40 ns rounded up to two 25 ns clocks (50 ns wide).
`timescale 1ns/1ps
`default_nettype none
`include "mpanel_consts.svh"

module maintenance_panel_control (
    input wire logic clk,
    input wire logic rstn,
    input wire mpanel_pkg::panel_t panel,
    input wire mpanel_pkg::ctrl_in_t ctrl_in,
    output mpanel_pkg::ctrl_out_t ctrl_out,
    output mpanel_pkg::lamps_t lamps
);
    import mpanel_pkg::*;

    localparam int SYNC_CYC = `MP_SYNC_PULSE_CYC;
    localparam logic [1:0] SYNC_CYC_W = 2'(SYNC_CYC);

    if (SYNC_CYC < 1 || SYNC_CYC > 3) begin : g_chk
        $error("sync pulse length does not fit its counter");
    end

    typedef struct packed {
        logic halted;
        logic pending;
        logic pend_inline;
        mode_t pend_mode;
        logic [15:0] storage_data_addr_reg;
        logic [15:0] cmp;
        logic [3:0][7:0] stage;
        logic [31:0] fetch_data;
        logic fetch_wait;
        logic microcode_load_mode_busy;
        logic match_one;
        logic match_two;
        logic [1:0] sync_cnt;
        logic [10:0] err_latch;
        ctrl_out_t co;
        lamps_t lp;
    } st_t;

    st_t q;
    st_t d;

    panel_t sw_level;
    panel_t sw_rise;
    logic [$bits(panel_t)-1:0] lvl_bits;
    logic [$bits(panel_t)-1:0] rise_bits;

    panel_sync #(
        .W($bits(panel_t))
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .raw(panel),
        .level(lvl_bits),
        .rise(rise_bits)
    );

    assign sw_level = panel_t'(lvl_bits);
    assign sw_rise = panel_t'(rise_bits);

    logic is_ce;
    logic is_inline;
    logic hit_one;
    logic stop_one;
    logic sync_one;
    logic hit_two;
    logic stop_two;
    logic sync_two;

    assign is_ce = (sw_level.function_sel == fn_engineer);
    assign is_inline = (sw_level.function_sel == fn_inline);

    addr_match u_match_one (
        .enable(is_ce),
        .setting(sw_level.stop_sync_one),
        .iar_load(ctrl_in.iar_load),
        .iar_value(ctrl_in.iar_value),
        .target(sw_level.cs_addr_sw),
        .hit(hit_one),
        .stop_hit(stop_one),
        .sync_hit(sync_one)
    );

    addr_match u_match_two (
        .enable(is_ce),
        .setting(sw_level.stop_sync_two),
        .iar_load(ctrl_in.iar_load),
        .iar_value(ctrl_in.iar_value),
        .target(q.cmp),
        .hit(hit_two),
        .stop_hit(stop_two),
        .sync_hit(sync_two)
    );

    always_comb begin
        policy_t pol;
        logic [4:0] idx;
        logic execute_switch_ok;
        logic mode_ok;
        logic stage_sel;
        logic [1:0] stage_slot;
        logic clr;
        pol = is_ce ? sw_level.policy : pol_normal;
        idx = {sw_level.reg_sel, sw_level.inner_outer};
        stage_sel = (idx >= `MP_STAGE_FIRST_IDX) && (idx <= `MP_STAGE_LAST_IDX);
        stage_slot = 2'(idx - `MP_STAGE_FIRST_IDX);
        clr = sw_rise.check_reset_sw;
        d = q;
        d.co.step_grant = 1'b0;
        d.co.jump_req = 1'b0;
        d.co.uprog_reset = 1'b0;
        d.co.reg_wr = 1'b0;
        d.co.cs_wr = 1'b0;
        d.co.cs_rd = 1'b0;
        d.co.microcode_load_mode_start = 1'b0;
        d.co.reg_idx = idx;

        // Execute is taken in engineer and inline functions only.
        mode_ok = (sw_level.mode == run_mode) || (sw_level.mode == loop_between_addrs_mode) ||
                  (sw_level.mode == compare_load_mode) || (pol == pol_single_step);
        execute_switch_ok = sw_rise.execute_switch && !q.pending && (is_inline || (is_ce && mode_ok));
        if (execute_switch_ok) begin
            d.pending = 1'b1;
            d.pend_inline = is_inline;
            d.pend_mode = sw_level.mode;
        end

        // The command waits until the microprogram is free to branch to it.
        if (q.pending && ctrl_in.prog_ready) begin
            d.pending = 1'b0;
            if (q.pend_inline) begin
                d.co.jump_req = 1'b1;
                d.co.jump_addr = sw_level.cs_addr_sw;
                d.halted = 1'b0;
            end else begin
                unique case (q.pend_mode)
                    loop_between_addrs_mode, run_mode: begin
                        if (pol == pol_single_step) begin
                            d.co.step_grant = 1'b1;
                        end else begin
                            d.co.jump_req = 1'b1;
                            d.co.jump_addr = sw_level.cs_addr_sw;
                            d.halted = 1'b0;
                        end
                    end
                    storage_addr_load_mode: begin
                        d.storage_data_addr_reg = sw_level.cs_addr_sw;
                    end
                    compare_load_mode: begin
                        d.cmp = sw_level.cs_addr_sw;
                    end
                    data_load_mode: begin
                        if (stage_sel) begin
                            d.stage[stage_slot] = sw_level.data_sw;
                        end else begin
                            d.co.reg_wr = 1'b1;
                            d.co.reg_wr_data = sw_level.data_sw;
                        end
                    end
                    storage_write_mode: begin
                        d.co.cs_wr = 1'b1;
                        d.co.cs_addr = q.storage_data_addr_reg;
                        d.co.cs_wr_data = {q.stage[0], q.stage[1], q.stage[2], q.stage[3]};
                    end
                    storage_fetch_mode: begin
                        d.co.cs_rd = 1'b1;
                        d.co.cs_addr = q.storage_data_addr_reg;
                        d.fetch_wait = 1'b1;
                    end
                    microcode_load_mode: begin
                        d.co.microcode_load_mode_start = 1'b1;
                        d.microcode_load_mode_busy = 1'b1;
                    end
                    default: begin
                        d.pending = 1'b0;
                    end
                endcase
            end
        end

        if (q.fetch_wait && ctrl_in.cs_rd_valid) begin
            d.fetch_wait = 1'b0;
            d.fetch_data = ctrl_in.cs_rd_data;
        end

        if (q.microcode_load_mode_busy && ctrl_in.microcode_load_mode_done) begin
            d.microcode_load_mode_busy = 1'b0;
            d.storage_data_addr_reg = `MP_UCODE_LOADED_ADDR;
        end

        if (is_ce && sw_rise.uprog_reset_sw) begin
            d.co.uprog_reset = 1'b1;
            d.co.jump_addr = `MP_RESET_ADDR;
            d.storage_data_addr_reg = `MP_DAR_RST;
        end

        // Halting follows the error policy, and either match unit in stop setting.
        if (ctrl_in.hard_check && (pol == pol_normal || pol == pol_stop_on_error)) begin
            d.halted = 1'b1;
        end
        if (ctrl_in.control_check && pol == pol_stop_on_error) begin
            d.halted = 1'b1;
        end
        if (stop_one || stop_two) begin
            d.halted = 1'b1;
        end

        // Recycle: a hit on the compare address sends the program back to the switch address.
        if (is_ce && sw_level.mode == loop_between_addrs_mode && hit_two && !stop_two) begin
            d.co.jump_req = 1'b1;
            d.co.jump_addr = sw_level.cs_addr_sw;
        end

        // Sticky flags: a new event in the clearing cycle survives the clear.
        d.err_latch = (clr ? 11'h000 : q.err_latch) | ctrl_in.err_conds;
        d.match_one = (clr ? 1'b0 : q.match_one) | hit_one;
        d.match_two = (clr ? 1'b0 : q.match_two) | hit_two;

        if (sync_one || sync_two) begin
            d.sync_cnt = SYNC_CYC_W;
        end else if (q.sync_cnt != 2'h0) begin
            d.sync_cnt = q.sync_cnt - 2'h1;
        end

        d.co.run_enable = !d.halted && (pol != pol_single_step);

        unique case (sw_level.display_sel)
            routine_error_view: d.lp.display_bus = {ctrl_in.routine_code, ctrl_in.error_code};
            ab_view: d.lp.display_bus = {ctrl_in.a_bus, ctrl_in.b_bus};
            dsel_data_addr: d.lp.display_bus = d.storage_data_addr_reg;
            dsel_mem_lo: d.lp.display_bus = q.fetch_data[31:16];
            dsel_mem_hi: d.lp.display_bus = q.fetch_data[15:0];
            dsel_instr_addr: d.lp.display_bus = ctrl_in.iar_value;
            dsel_compare: d.lp.display_bus = q.cmp;
            dsel_switches: d.lp.display_bus = sw_level.cs_addr_sw;
        endcase
        if (!is_ce && !is_inline) begin
            d.lp.register_display = 9'h000;
        end else if (stage_sel) begin
            d.lp.register_display = {~^d.stage[stage_slot], d.stage[stage_slot]};
        end else begin
            d.lp.register_display = ctrl_in.reg_rd_data;
        end
        d.lp.error_display = d.err_latch;
        d.lp.execute_switch_delayed = d.pending;
        d.lp.microcode_load_mode_lamp = d.microcode_load_mode_busy;
        d.lp.match_lamp_one = d.match_one;
        d.lp.match_lamp_two = d.match_two;
        d.lp.stop_lamp = d.halted;
        d.lp.sync_pulse = (d.sync_cnt != 2'h0);

        if (sw_level.lamp_test_sw) begin
            d.lp.display_bus = 16'hffff;
            d.lp.register_display = 9'h1ff;
            d.lp.error_display = 11'h7ff;
            d.lp.execute_switch_delayed = 1'b1;
            d.lp.microcode_load_mode_lamp = 1'b1;
            d.lp.match_lamp_one = 1'b1;
            d.lp.match_lamp_two = 1'b1;
            d.lp.stop_lamp = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.storage_data_addr_reg <= `MP_DAR_RST;
            q.cmp <= `MP_CMP_RST;
            q.pend_mode <= run_mode;
            q.stage <= {4{`MP_STAGE_RST}};
        end else begin
            q <= d;
        end
    end

    assign ctrl_out = q.co;
    assign lamps = q.lp;

endmodule

`default_nettype wire

// ---- tb/mpanel_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mpanel_consts.svh"

module mpanel_props (
    input wire logic clk,
    input wire logic rstn,
    input wire mpanel_pkg::panel_t panel,
    input wire mpanel_pkg::ctrl_in_t ctrl_in,
    input wire mpanel_pkg::ctrl_out_t ctrl_out,
    input wire mpanel_pkg::lamps_t lamps
);
    import mpanel_pkg::*;
    logic [3:0] lt_q;
    logic [3:0] nrm_q;
    logic quiet;
    logic ce;
    assign quiet = (lt_q == 4'h0);
    assign ce = (panel.function_sel == fn_engineer);
    // Lamp test masks the lamps for a while after release, so lamp checks wait.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lt_q <= 4'h0;
            nrm_q <= 4'h0;
        end else begin
            lt_q <= panel.lamp_test_sw ? 4'h8 : ((lt_q != 4'h0) ? lt_q - 4'h1 : lt_q);
            nrm_q <= (panel.function_sel != fn_normal) ? 4'h0 : ((nrm_q != 4'h8) ? nrm_q + 4'h1 : nrm_q);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_REG_WR: assert property (
        ctrl_out.reg_wr |-> ctrl_out.reg_wr_data == panel.data_sw
        && ctrl_out.reg_idx == {panel.reg_sel, panel.inner_outer}) else $error("register write mismatch");
    AST_ONE_PULSE: assert property (
        ctrl_out.reg_wr || ctrl_out.cs_wr |=> !ctrl_out.reg_wr && !ctrl_out.cs_wr) else $error("double command");
    AST_DELAY_DONE: assert property (
        lamps.execute_switch_delayed && ctrl_in.prog_ready && quiet |=> !lamps.execute_switch_delayed) else $error("delay lamp stuck");
    AST_NORMAL_QUIET: assert property (
        nrm_q == 4'h8 |-> !(ctrl_out.reg_wr || ctrl_out.cs_wr || ctrl_out.cs_rd || ctrl_out.jump_req
        || ctrl_out.step_grant || ctrl_out.microcode_load_mode_start || ctrl_out.uprog_reset)) else $error("command in normal");
    AST_RESET_ZERO: assert property (
        ctrl_out.uprog_reset |-> ctrl_out.jump_addr == `MP_RESET_ADDR) else $error("reset address wrong");
    AST_SYNC_WIDTH: assert property (
        $rose(lamps.sync_pulse) |=> lamps.sync_pulse ##1 !lamps.sync_pulse) else $error("sync width wrong");
    AST_MATCH_ONE: assert property (
        ce && quiet && ctrl_in.iar_load && ctrl_in.iar_value == panel.cs_addr_sw
        && panel.stop_sync_one != ss_off |=> lamps.match_lamp_one) else $error("match lamp dark");
    AST_MATCH_STOP: assert property (
        ce && quiet && ctrl_in.iar_load && ctrl_in.iar_value == panel.cs_addr_sw
        && panel.stop_sync_one == ss_stop |=> lamps.stop_lamp && !ctrl_out.run_enable) else $error("no stop");
    AST_HARD_HALT: assert property (
        ce && quiet && ctrl_in.hard_check && (panel.policy == pol_normal || panel.policy == pol_stop_on_error)
        |=> lamps.stop_lamp && !ctrl_out.run_enable) else $error("no halt on hard check");
    AST_RUN_ON_ERR: assert property (
        ce && panel.policy == pol_run_on_error && ctrl_out.run_enable
        && (ctrl_in.hard_check || ctrl_in.control_check) |=> ctrl_out.run_enable) else $error("halt on error");
    AST_UCODE_END: assert property (
        $fell(lamps.microcode_load_mode_lamp) && quiet && panel.display_sel == dsel_data_addr
        |-> ##[0:2] lamps.display_bus == `MP_UCODE_LOADED_ADDR) else $error("load end address wrong");
    cover property (ctrl_out.cs_wr);
    cover property ($rose(lamps.sync_pulse));
    cover property (ctrl_out.microcode_load_mode_start);
endmodule
`default_nettype wire

// ---- tb/panel_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module panel_model (
    input wire logic clk,
    input wire mpanel_pkg::panel_t levers,
    output mpanel_pkg::panel_t panel
);
    import mpanel_pkg::*;
    logic [2:0] btn_q = 3'h0;
    always_comb begin
        panel = levers;
        panel.execute_switch = btn_q[0];
        panel.uprog_reset_sw = btn_q[1];
        panel.check_reset_sw = btn_q[2];
    end
    // A push is held across several clocks, as a hand would, then released.
    task automatic press(input int b, input int hold);
        @(posedge clk);
        btn_q[b] <= 1'b1;
        repeat (hold) @(posedge clk);
        btn_q <= 3'h0;
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ---- tb/maintenance_panel_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mpanel_consts.svh"

module maintenance_panel_control_tb;
    import mpanel_pkg::*;
    logic clk;
    logic rstn;
    panel_t sw;
    panel_t panel;
    ctrl_in_t ci;
    ctrl_out_t co;
    ctrl_out_t co_q;
    lamps_t lamps;
    logic [7:0] stg [4];
    int num_errors = 0;
    int total_checks = 0;
    int n_wr = 0, n_cw = 0, n_cr = 0, n_jmp = 0, n_stp = 0, n_imp = 0, n_rst = 0, n_syn = 0;

    panel_model u_panel_model (.clk(clk), .levers(sw), .panel(panel));
    maintenance_panel_control u_maintenance_panel_control (
        .clk(clk), .rstn(rstn), .panel(panel), .ctrl_in(ci), .ctrl_out(co), .lamps(lamps));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (co.reg_wr) n_wr++;
        if (co.cs_wr) n_cw++;
        if (co.cs_rd) n_cr++;
        if (co.jump_req) n_jmp++;
        if (co.step_grant) n_stp++;
        if (co.microcode_load_mode_start) n_imp++;
        if (co.uprog_reset) n_rst++;
        if (lamps.sync_pulse) n_syn++;
        if (co.reg_wr | co.cs_wr | co.cs_rd | co.jump_req | co.uprog_reset) co_q = co;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic ex();
        tick(4);
        u_panel_model.press(0, 4);
    endtask
    task automatic microinstr_addr_reg(input logic [15:0] a);
        ci.iar_value <= a;
        ci.iar_load <= 1'b1;
        tick(1);
        ci.iar_load <= 1'b0;
        tick(4);
    endtask
    task automatic t_load();
        logic [4:0] idx;
        sw.mode <= data_load_mode;
        ci.prog_ready <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            idx = 5'h1c + 5'(i);
            stg[i] = 8'h81 + 8'(i) * 8'h16;
            sw.reg_sel <= idx[4:1];
            sw.inner_outer <= idx[0];
            sw.data_sw <= stg[i];
            ex();
            if (i == 0) begin
                chk(lamps.execute_switch_delayed, 1'b1);
                chk(n_wr, 0);
                ci.prog_ready <= 1'b1;
                tick(3);
            end
            chk(n_wr, 0);
            chk(co.reg_idx, idx);
            chk(lamps.execute_switch_delayed, 1'b0);
            chk(lamps.register_display, {~^stg[i], stg[i]});
        end
        sw.reg_sel <= 4'h2;
        sw.inner_outer <= 1'b1;
        sw.data_sw <= 8'h3c;
        ci.reg_rd_data <= 9'h13c;
        ex();
        chk(n_wr, 1);
        chk(co_q.reg_wr_data, 8'h3c);
        chk(co_q.reg_idx, 5'h05);
        chk(lamps.register_display, 9'h13c);
    endtask
    task automatic t_mem();
        sw.mode <= storage_addr_load_mode;
        sw.cs_addr_sw <= 16'h0123;
        ex();
        sw.mode <= storage_write_mode;
        ex();
        chk(n_cw, 1);
        chk(co_q.cs_addr, 16'h0123);
        chk(co_q.cs_wr_data, {stg[0], stg[1], stg[2], stg[3]});
        sw.mode <= storage_fetch_mode;
        ex();
        chk(n_cr, 1);
        chk(co_q.cs_addr, 16'h0123);
        ci.cs_rd_data <= 32'h89ab_cdef;
        ci.cs_rd_valid <= 1'b1;
        tick(1);
        ci.cs_rd_valid <= 1'b0;
    endtask
    task automatic t_match();
        sw.policy <= pol_normal;
        sw.mode <= run_mode;
        ex();
        sw.mode <= compare_load_mode;
        sw.cs_addr_sw <= 16'h0040;
        ex();
        sw.stop_sync_two <= ss_sync;
        sw.mode <= loop_between_addrs_mode;
        tick(4);
        microinstr_addr_reg(16'h0041);
        chk(lamps.match_lamp_two, 1'b0);
        microinstr_addr_reg(16'h0040);
        chk(lamps.match_lamp_two, 1'b1);
        chk(n_syn, 2);
        chk(co_q.jump_addr, 16'h0040);
        chk(co.run_enable, 1'b1);
        sw.stop_sync_one <= ss_stop;
        sw.cs_addr_sw <= 16'h0055;
        tick(4);
        microinstr_addr_reg(16'h0055);
        chk(lamps.match_lamp_one, 1'b1);
        chk(lamps.stop_lamp, 1'b1);
        chk(co.run_enable, 1'b0);
        u_panel_model.press(2, 4);
        chk({lamps.match_lamp_one, lamps.match_lamp_two}, 2'b00);
        sw.stop_sync_one <= ss_off;
        sw.stop_sync_two <= ss_off;
    endtask
    task automatic t_disp();
        logic [15:0] e [8];
        e = '{{ci.routine_code, ci.error_code}, {ci.a_bus, ci.b_bus}, 16'h0123, 16'h89ab, 16'hcdef,
            16'h0055, 16'h0040, 16'h0055};
        for (int i = 0; i < 8; i++) begin
            sw.display_sel <= dsel_t'(i);
            tick(5);
            chk(lamps.display_bus, e[i]);
        end
    endtask
    task automatic t_err();
        logic halt;
        for (int p = 0; p < 4; p++) begin
            for (int h = 0; h < 2; h++) begin
                if (p != 2) begin
                    sw.policy <= policy_t'(p);
                    sw.mode <= run_mode;
                    ex();
                    chk(co.run_enable, 1'b1);
                    ci.hard_check <= (h == 1);
                    ci.control_check <= (h == 0);
                    tick(1);
                    ci.hard_check <= 1'b0;
                    ci.control_check <= 1'b0;
                    tick(3);
                    halt = (p == 3) || (p == 0 && h == 1);
                    chk(co.run_enable, !halt);
                    chk(lamps.stop_lamp, halt);
                end
            end
        end
        u_panel_model.press(2, 4);
        ci.err_conds <= 11'h401;
        tick(1);
        ci.err_conds <= 11'h000;
        tick(3);
        chk(lamps.error_display, 11'h401);
        u_panel_model.press(2, 4);
        chk(lamps.error_display, 11'h000);
    endtask
    task automatic t_step();
        sw.policy <= pol_single_step;
        sw.mode <= run_mode;
        ex();
        ex();
        chk(n_stp, 2);
        chk(co.run_enable, 1'b0);
        sw.policy <= pol_normal;
        sw.mode <= data_load_mode;
        ex();
        chk(n_wr, 1);
    endtask
    task automatic t_func();
        int j;
        j = n_jmp;
        sw.function_sel <= fn_normal;
        sw.mode <= run_mode;
        ex();
        u_panel_model.press(1, 4);
        chk(n_jmp, j);
        chk(n_rst, 0);
        sw.lamp_test_sw <= 1'b1;
        tick(5);
        chk({lamps.stop_lamp, lamps.match_lamp_one, lamps.display_bus}, 18'h3ffff);
        sw.lamp_test_sw <= 1'b0;
        sw.function_sel <= fn_inline;
        sw.cs_addr_sw <= 16'h0234;
        sw.mode <= data_load_mode;
        ex();
        chk(n_jmp, j + 1);
        chk(co_q.jump_addr, 16'h0234);
        chk(n_wr, 1);
        u_panel_model.press(1, 4);
        chk(n_rst, 0);
        sw.function_sel <= fn_engineer;
        tick(8);
    endtask
    task automatic t_reset();
        sw.display_sel <= dsel_data_addr;
        u_panel_model.press(1, 4);
        chk(n_rst, 1);
        chk(co_q.jump_addr, 16'h0000);
        chk(lamps.display_bus, 16'h0000);
        sw.policy <= pol_single_step;
        sw.mode <= microcode_load_mode;
        ex();
        chk(n_imp, 1);
        chk(lamps.microcode_load_mode_lamp, 1'b1);
        ci.microcode_load_mode_done <= 1'b1;
        tick(1);
        ci.microcode_load_mode_done <= 1'b0;
        tick(3);
        chk(lamps.microcode_load_mode_lamp, 1'b0);
        chk(lamps.display_bus, `MP_UCODE_LOADED_ADDR);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done();
    end
    initial begin
        rstn = 1'b0;
        sw = '0;
        sw.function_sel = fn_engineer;
        sw.policy = pol_single_step;
        ci = '0;
        ci.prog_ready = 1'b1;
        ci.routine_code = 8'h5a;
        ci.error_code = 8'hc3;
        ci.a_bus = 8'h12;
        ci.b_bus = 8'hef;
        tick(10);
        rstn <= 1'b1;
        tick(6);
        t_load();
        t_mem();
        t_match();
        t_disp();
        t_err();
        t_step();
        t_func();
        t_reset();
        test_done();
    end
endmodule

bind maintenance_panel_control mpanel_props u_mpanel_props (
    .clk(clk), .rstn(rstn), .panel(panel), .ctrl_in(ctrl_in), .ctrl_out(ctrl_out), .lamps(lamps));
`default_nettype wire
